/* cpu_status_flag_register.v */
`timescale 1ns/1ps
`include "cpu_status_flags_defs.vh"
module cpu_status_flag_register (
  input wire I_CLK,
  input wire I_RST,
  input wire [3:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire i_acc_a_overflow,
  input wire i_acc_b_overflow,
  input wire i_acc_a_saturate,
  input wire i_acc_b_saturate,
  input wire i_loop_active,
  input wire i_hc_valid,
  input wire i_hc_byte,
  input wire [7:0] i_hc_op_a,
  input wire [7:0] i_hc_op_b,
  input wire i_hc_sub,
  output reg [15:0] o_rdata,
  output wire [3:0] o_cpu_priority_level,
  output wire o_user_irq_disable,
  output wire o_irq
);

  // Datapath flag state.
  reg acc_a_overflow_reg;
  reg acc_b_overflow_reg;
  reg loop_active_reg;
  reg half_carry_reg;

  // Priority and control state.
  reg [2:0] prio_low_reg;
  reg prio_hi_reg;
  reg nesting_disable_reg;
  reg [`EVT_WIDTH-1:0] evt_mask_reg;

  // Combinational next values and helpers.
  reg [15:0] rdata_next;
  reg [`EVT_WIDTH-1:0] evt_set;
  wire [1:0] ovf_vec;
  wire [1:0] ovf_rise_vec;
  wire [1:0] sat_vec;
  wire [1:0] clip_wr_vec;
  wire [1:0] clipped_vec;
  wire [`EVT_WIDTH-1:0] evt_status_vec;
  wire either_acc_overflow;
  wire either_acc_clipped_sticky;
  wire wr_status;
  wire wr_core_control;
  wire wr_irq_control;
  wire wr_evt_status;
  wire wr_evt_mask;
  wire hc_carry;
  wire [15:0] status_word;
  // Generate loop indices.
  genvar acc;
  genvar evt;

  // Address decode used by the write path; the read path decodes with a case.
  function sel;
    input [3:0] addr;
    input [3:0] target;
    begin
      sel = (addr == target);
    end
  endfunction

  // Half carry: carry or borrow out of the low nibble for bytes, low byte for words.
  function hc_out;
    input [7:0] a;
    input [7:0] b;
    input sub;
    input is_byte;
    reg [8:0] sum;
    reg [4:0] nib;
    begin
      sum = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
      nib = sub ? ({1'b0, a[3:0]} - {1'b0, b[3:0]}) : ({1'b0, a[3:0]} + {1'b0, b[3:0]});
      hc_out = is_byte ? nib[4] : sum[8];
    end
  endfunction

  // Write decode, one strobe per register, shared by every writable register below.
  assign wr_status = i_wr && sel(i_addr, `ADDR_STATUS_FLAGS);
  assign wr_core_control = i_wr && sel(i_addr, `ADDR_CORE_CONTROL);
  assign wr_irq_control = i_wr && sel(i_addr, `ADDR_IRQ_CONTROL_ONE);
  assign wr_evt_status = i_wr && sel(i_addr, `ADDR_EVT_STATUS);
  assign wr_evt_mask = i_wr && sel(i_addr, `ADDR_EVT_MASK);

  // Per-accumulator inputs gathered into vectors; index 0 is accumulator A, index 1 accumulator B.
  assign ovf_vec = {i_acc_b_overflow, i_acc_a_overflow};
  assign sat_vec = {i_acc_b_saturate, i_acc_a_saturate};
  assign clip_wr_vec = {i_wdata[`BIT_ACC_B_CLIPPED], i_wdata[`BIT_ACC_A_CLIPPED]};

  // Half carry of the operands presented this cycle.
  assign hc_carry = hc_out(i_hc_op_a, i_hc_op_b, i_hc_sub, i_hc_byte);

  // Combined flags are pure ORs, so a write can never set them directly.
  assign either_acc_overflow = acc_a_overflow_reg | acc_b_overflow_reg;
  assign either_acc_clipped_sticky = |clipped_vec;

  // Priority outputs come straight from registers, so they never glitch.
  assign o_cpu_priority_level = {prio_hi_reg, prio_low_reg};
  assign o_user_irq_disable = prio_hi_reg;

  // Level interrupt: high while any unmasked event bit is set.
  assign o_irq = |(evt_status_vec & evt_mask_reg);

  // Status word assembled field by field from the shared bit positions.
  assign status_word[`BIT_ACC_A_OVERFLOW] = acc_a_overflow_reg;
  assign status_word[`BIT_ACC_B_OVERFLOW] = acc_b_overflow_reg;
  assign status_word[`BIT_ACC_A_CLIPPED] = clipped_vec[0];
  assign status_word[`BIT_ACC_B_CLIPPED] = clipped_vec[1];
  assign status_word[`BIT_EITHER_OVERFLOW] = either_acc_overflow;
  assign status_word[`BIT_EITHER_CLIPPED] = either_acc_clipped_sticky;
  assign status_word[`BIT_LOOP_ACTIVE] = loop_active_reg;
  assign status_word[`BIT_HALF_CARRY] = half_carry_reg;
  assign status_word[`BIT_PRIO_HI:`BIT_PRIO_LO] = prio_low_reg;
  // The low arithmetic flags are kept elsewhere in the core, so they read zero here.
  assign status_word[4:0] = 5'h00;

  // Previous overflow level per accumulator, for the overflow events.
  generate
    for (acc = 0; acc < 2; acc = acc + 1) begin : ovf_track
      reg prev_ovf_reg;
      always @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
          prev_ovf_reg <= 1'b0;
        end else begin
          prev_ovf_reg <= ovf_vec[acc];
        end
      end
      // Only a fresh overflow raises an event; a held overflow does not retrigger it.
      assign ovf_rise_vec[acc] = ovf_vec[acc] & ~prev_ovf_reg;
    end
  endgenerate

  // Overflow flags follow the accumulators every cycle and read zero once the overflow is gone.
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      acc_a_overflow_reg <= 1'b0;
      acc_b_overflow_reg <= 1'b0;
    end else begin
      acc_a_overflow_reg <= i_acc_a_overflow;
      acc_b_overflow_reg <= i_acc_b_overflow;
    end
  end

  // Loop flag mirrors the loop hardware; software writes cannot reach it.
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      loop_active_reg <= 1'b0;
    end else begin
      loop_active_reg <= i_loop_active;
    end
  end

  // Half carry: an ALU result wins over a software write in the same cycle.
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      half_carry_reg <= 1'b0;
    end else begin
      if (i_hc_valid) begin
        half_carry_reg <= hc_carry;
      end else if (wr_status) begin
        half_carry_reg <= i_wdata[`BIT_HALF_CARRY];
      end
    end
  end

  // Clipped flags: saturation wins over a software write in the same cycle, so no saturation is lost.
  // Software should write both flags at once; a bit operation could race with a saturating accumulator.
  generate
    for (acc = 0; acc < 2; acc = acc + 1) begin : clip_flag
      reg clipped_bit_reg;
      always @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
          clipped_bit_reg <= 1'b0;
        end else if (sat_vec[acc]) begin
          clipped_bit_reg <= 1'b1;
        end else if (wr_status) begin
          clipped_bit_reg <= clip_wr_vec[acc] & i_wdata[`BIT_EITHER_CLIPPED];
        end
      end
      assign clipped_vec[acc] = clipped_bit_reg;
    end
  endgenerate

  // Low priority bits are frozen while nesting is disabled, so a handler cannot lower its own level through the status register.
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      prio_low_reg <= 3'h0;
    end else if (wr_status && !nesting_disable_reg) begin
      prio_low_reg <= i_wdata[`BIT_PRIO_HI:`BIT_PRIO_LO];
    end
  end

  // Upper priority bit, kept in the core control register.
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      prio_hi_reg <= 1'b0;
    end else if (wr_core_control) begin
      prio_hi_reg <= i_wdata[`BIT_CORE_PRIO3];
    end
  end

  // Nesting disable bit, kept in interrupt control register one.
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      nesting_disable_reg <= 1'b0;
    end else if (wr_irq_control) begin
      nesting_disable_reg <= i_wdata[`BIT_NESTING_DISABLE];
    end
  end

  // Rising overflow and every saturating cycle are the interrupt events.
  // A saturation held for several cycles sets the event each cycle, which the sticky bit absorbs.
  always @* begin
    evt_set = `RESET_EVT;
    evt_set[`EVT_ACC_A_OVERFLOW] = ovf_rise_vec[0];
    evt_set[`EVT_ACC_B_OVERFLOW] = ovf_rise_vec[1];
    evt_set[`EVT_ACC_A_CLIPPED] = sat_vec[0];
    evt_set[`EVT_ACC_B_CLIPPED] = sat_vec[1];
  end

  // One sticky bit per event, cleared by writing one; a new event beats the clear, so none is dropped.
  generate
    for (evt = 0; evt < `EVT_WIDTH; evt = evt + 1) begin : evt_bit
      reg status_bit_reg;
      always @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
          status_bit_reg <= 1'b0;
        end else if (evt_set[evt]) begin
          status_bit_reg <= 1'b1;
        end else if (wr_evt_status && i_wdata[evt]) begin
          status_bit_reg <= 1'b0;
        end
      end
      assign evt_status_vec[evt] = status_bit_reg;
    end
  endgenerate

  // Event mask, same layout as the event status.
  // Masking only gates the interrupt output; masked events are still recorded.
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      evt_mask_reg <= `RESET_EVT;
    end else if (wr_evt_mask) begin
      evt_mask_reg <= i_wdata[`EVT_WIDTH-1:0];
    end
  end

  // Read mux; unmapped addresses read zero.
  always @* begin
    rdata_next = 16'h0000;
    case (i_addr)
      `ADDR_STATUS_FLAGS: begin
        rdata_next = status_word;
      end
      `ADDR_CORE_CONTROL: begin
        rdata_next[`BIT_CORE_PRIO3] = prio_hi_reg;
      end
      `ADDR_IRQ_CONTROL_ONE: begin
        rdata_next[`BIT_NESTING_DISABLE] = nesting_disable_reg;
      end
      `ADDR_EVT_STATUS: begin
        rdata_next[`EVT_WIDTH-1:0] = evt_status_vec;
      end
      `ADDR_EVT_MASK: begin
        rdata_next[`EVT_WIDTH-1:0] = evt_mask_reg;
      end
      default: begin
        rdata_next = 16'h0000;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  // Returning to zero keeps a stale word from being mistaken for a fresh read.
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      o_rdata <= rdata_next;
    end else begin
      o_rdata <= 16'h0000;
    end
  end

endmodule

/* cpu_status_flags_defs.vh */
`ifndef CPU_STATUS_FLAGS_DEFS_VH
`define CPU_STATUS_FLAGS_DEFS_VH

// Register addresses on the plain register port (word indices).
`define ADDR_STATUS_FLAGS 4'h0
`define ADDR_CORE_CONTROL 4'h1
`define ADDR_IRQ_CONTROL_ONE 4'h2
`define ADDR_EVT_STATUS 4'h3
`define ADDR_EVT_MASK 4'h4

// Field positions of the status flag register.
`define BIT_ACC_A_OVERFLOW 15
`define BIT_ACC_B_OVERFLOW 14
`define BIT_ACC_A_CLIPPED 13
`define BIT_ACC_B_CLIPPED 12
`define BIT_EITHER_OVERFLOW 11
`define BIT_EITHER_CLIPPED 10
`define BIT_LOOP_ACTIVE 9
`define BIT_HALF_CARRY 8
`define BIT_PRIO_HI 7
`define BIT_PRIO_LO 5

// Field positions of the core control and interrupt control registers.
`define BIT_CORE_PRIO3 3
`define BIT_NESTING_DISABLE 15

// Event status bits.
`define EVT_ACC_A_OVERFLOW 0
`define EVT_ACC_B_OVERFLOW 1
`define EVT_ACC_A_CLIPPED 2
`define EVT_ACC_B_CLIPPED 3
`define EVT_WIDTH 4

// Reset values.
`define RESET_FLAGS 16'h0000
`define RESET_EVT 4'h0

`endif

/* cpu_status_flag_props.sv */
`timescale 1ns/1ps
module cpu_status_flag_props (
  input wire I_CLK,
  input wire I_RST,
  input wire [3:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire i_acc_a_overflow,
  input wire i_acc_b_overflow,
  input wire i_acc_a_saturate,
  input wire i_loop_active,
  input wire i_hc_valid,
  input wire i_hc_byte,
  input wire [7:0] i_hc_op_a,
  input wire [7:0] i_hc_op_b,
  input wire i_hc_sub,
  input wire [15:0] o_rdata,
  input wire [3:0] o_cpu_priority_level,
  input wire o_user_irq_disable
);
  // Carry or borrow out of the nibble or the low byte, as the ALU should see it.
  wire [4:0] nib = i_hc_sub ? {1'b0, i_hc_op_a[3:0]} - {1'b0, i_hc_op_b[3:0]} : {1'b0, i_hc_op_a[3:0]} + {1'b0, i_hc_op_b[3:0]};
  wire [8:0] wrd = i_hc_sub ? {1'b0, i_hc_op_a} - {1'b0, i_hc_op_b} : {1'b0, i_hc_op_a} + {1'b0, i_hc_op_b};
  wire hc_exp = i_hc_byte ? nib[4] : wrd[8];
  wire rd_st = i_rd && i_addr == 4'h0;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  // Event followed at once by a status read.
  sequence sat_rd_s; i_acc_a_saturate ##1 rd_st; endsequence
  sequence hc_rd_s; i_hc_valid ##1 rd_st; endsequence
  ovf_flags_a: assert property (rd_st && $stable({i_acc_a_overflow, i_acc_b_overflow})
    |=> o_rdata[15:14] == $past({i_acc_a_overflow, i_acc_b_overflow})) else $error("overflow flags wrong");
  sticky_clip_a: assert property (sat_rd_s |=> o_rdata[13]) else $error("clipped flag not set");
  either_ovf_a: assert property (rd_st |=> o_rdata[11] == (o_rdata[15] | o_rdata[14]))
    else $error("combined overflow wrong");
  either_clip_a: assert property (rd_st |=> o_rdata[10] == (o_rdata[13] | o_rdata[12]))
    else $error("combined clipped wrong");
  loop_flag_a: assert property (rd_st && $stable(i_loop_active) |=> o_rdata[9] == $past(i_loop_active))
    else $error("loop flag wrong");
  half_carry_a: assert property (hc_rd_s |=> o_rdata[8] == $past(hc_exp, 2)) else $error("half carry wrong");
  prio_copy_a: assert property (rd_st |=> o_rdata[7:5] == $past(o_cpu_priority_level[2:0]))
    else $error("priority bits differ");
  irq_off_a: assert property (o_user_irq_disable == o_cpu_priority_level[3]) else $error("disable wrong");
  core_prio_a: assert property (i_wr && i_addr == 4'h1 |=> o_user_irq_disable == $past(i_wdata[3]))
    else $error("upper priority bit not written");
  reset_zero_a: assert property (disable iff (1'b0) I_RST |-> o_rdata == 16'h0000 && o_cpu_priority_level == 4'h0)
    else $error("outputs not cleared in reset");
endmodule
bind cpu_status_flag_register cpu_status_flag_props u_props (.I_CLK, .I_RST, .i_addr, .i_wdata, .i_wr, .i_rd,
  .i_acc_a_overflow,
  .i_acc_b_overflow, .i_acc_a_saturate, .i_loop_active, .i_hc_valid, .i_hc_byte, .i_hc_op_a, .i_hc_op_b,
  .i_hc_sub, .o_rdata, .o_cpu_priority_level, .o_user_irq_disable);

/* cpu_status_flag_register_tb_top.sv */
`timescale 1ns/1ps
`include "cpu_status_flags_defs.vh"
module cpu_status_flag_register_tb_top;
  reg I_CLK = 1'b0;
  reg I_RST = 1'b0;
  reg [3:0] ad = 4'h0;
  reg [15:0] wd = 16'h0000;
  reg wr_s = 1'b0, rd_s = 1'b0, ova = 1'b0, ovb = 1'b0, sa = 1'b0, sb = 1'b0, lp = 1'b0;
  reg hv = 1'b0, hy = 1'b0, hs = 1'b0, ca = 1'b0, cb = 1'b0, hc = 1'b0;
  reg [7:0] ha = 8'h00, hb = 8'h00;
  reg [2:0] pr = 3'h0;
  reg [31:0] r;
  wire [15:0] rdata;
  wire [3:0] lvl;
  wire dis, irq;
  integer seed = 32'h0000_1265, num_errors = 0, checks_done = 0, cyc = 0, k;
  cpu_status_flag_register uut (.I_CLK(I_CLK), .I_RST(I_RST), .i_addr(ad), .i_wdata(wd), .i_wr(wr_s),
    .i_rd(rd_s), .i_acc_a_overflow(ova), .i_acc_b_overflow(ovb), .i_acc_a_saturate(sa), .i_acc_b_saturate(sb),
    .i_loop_active(lp), .i_hc_valid(hv), .i_hc_byte(hy), .i_hc_op_a(ha), .i_hc_op_b(hb), .i_hc_sub(hs),
    .o_rdata(rdata), .o_cpu_priority_level(lvl), .o_user_irq_disable(dis), .o_irq(irq));
  // Clock of 8 ns.
  initial begin
    forever #4 I_CLK = ~I_CLK;
  end
  // The sequence needs a few hundred cycles, so this guard only fires on a hang.
  always @(posedge I_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors = num_errors + 1;
      results;
    end
  end
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("ERROR %0t value %h expected %h", $time, got, exp);
      end
    end
  endtask
  task results;
    begin
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // Bus tasks start in the step of an edge and end one edge after the edge that samples the strobe.
  task wr(input [3:0] a, input [15:0] d);
    begin
      wr_s <= 1'b1; ad <= a; wd <= d;
      @(posedge I_CLK) wr_s <= 1'b0;
      @(posedge I_CLK);
    end
  endtask
  task rd(input [3:0] a, input [15:0] e);
    begin
      rd_s <= 1'b1; ad <= a;
      @(posedge I_CLK) rd_s <= 1'b0;
      #1 chk(rdata, e);
      @(posedge I_CLK);
    end
  endtask
  function [15:0] st(input dummy);
    st = {ova, ovb, ca, cb, ova | ovb, ca | cb, lp, hc, pr, 5'h00};
  endfunction
  function hcf(input [7:0] a, input [7:0] b, input s, input y);
    hcf = y ? (s ? a[3:0] < b[3:0] : a[3:0] + b[3:0] > 15) : (s ? a < b : a + b > 255);
  endfunction
  initial begin
    #1 I_RST = 1'b1;
    repeat (16) @(posedge I_CLK);
    I_RST <= 1'b0;
    rd(`ADDR_STATUS_FLAGS, 16'h0000);
    rd(`ADDR_EVT_STATUS, 16'h0000);
    // Random flags, saturation pulses and whole-register writes; a write with bit 10 low clears both clipped flags.
    for (k = 0; k < 40; k = k + 1) begin
      r = $random(seed);
      ova <= r[0]; ovb <= r[1]; lp <= r[2]; sa <= r[3] & r[4]; sb <= r[5] & r[6];
      @(posedge I_CLK) sa <= 1'b0;
      sb <= 1'b0;
      ca = ca | r[3] & r[4];
      cb = cb | r[5] & r[6];
      if (r[7]) begin
        wr(`ADDR_STATUS_FLAGS, r[31:16]);
        ca = r[29] & r[26]; cb = r[28] & r[26]; hc = r[24]; pr = r[23:21];
      end
      rd(`ADDR_STATUS_FLAGS, st(1'b0));
    end
    // Priority bits frozen while nesting is disabled, writable again after.
    wr(`ADDR_IRQ_CONTROL_ONE, 16'h8000);
    wr(`ADDR_STATUS_FLAGS, {8'h00, ~pr, 5'h00});
    ca = 1'b0; cb = 1'b0; hc = 1'b0;
    rd(`ADDR_STATUS_FLAGS, st(1'b0));
    wr(`ADDR_IRQ_CONTROL_ONE, 16'h0000);
    wr(`ADDR_STATUS_FLAGS, 16'h00E0);
    pr = 3'h7;
    rd(`ADDR_STATUS_FLAGS, st(1'b0));
    wr(`ADDR_CORE_CONTROL, 16'h0008);
    #1 chk({11'h000, dis, lvl}, {11'h001, 1'b1, pr});
    @(posedge I_CLK) wr(`ADDR_CORE_CONTROL, 16'h0000);
    #1 chk({11'h000, dis, lvl}, {12'h000, 1'b0, pr});
    // ALU results of random width and direction.
    for (k = 0; k < 24; k = k + 1) begin
      @(posedge I_CLK) r = $random(seed);
      hv <= 1'b1; hy <= r[0]; hs <= r[1]; ha <= r[15:8]; hb <= r[23:16];
      @(posedge I_CLK) hv <= 1'b0;
      hc = hcf(r[15:8], r[23:16], r[1], r[0]);
      rd(`ADDR_STATUS_FLAGS, st(1'b0));
    end
    // Saturation event: masked, then unmasked, then cleared by writing one.
    wr(`ADDR_EVT_STATUS, 16'h000F);
    wr(`ADDR_EVT_MASK, 16'h0000);
    sa <= 1'b1;
    @(posedge I_CLK) sa <= 1'b0;
    rd(`ADDR_EVT_STATUS, 16'h0004);
    chk({15'h0000, irq}, 16'h0000);
    wr(`ADDR_EVT_MASK, 16'h0004);
    #1 chk({15'h0000, irq}, 16'h0001);
    @(posedge I_CLK) wr(`ADDR_EVT_STATUS, 16'h0004);
    #1 chk({15'h0000, irq}, 16'h0000);
    @(posedge I_CLK) rd(4'hF, 16'h0000);
    results;
  end
endmodule
